/* src/eeprom_pkg.sv */
package eeprom_pkg;
   // Array geometry
   localparam int ADDR_W        = 15;
   localparam int PAGE_OFS_W    = 6;
   localparam int ROW_W         = ADDR_W - PAGE_OFS_W;
   localparam int PAGE_BYTES    = 64;
   localparam int MEM_BYTES     = 32768;
   localparam int BYTE_W        = 8;
   // Device address word layout
   localparam logic [3:0] DEV_TYPE_CODE = 4'ha;
   localparam int DEV_TYPE_HI   = 7;
   localparam int DEV_TYPE_LO   = 4;
   localparam int DEV_STRAP_HI  = 3;
   localparam int DEV_STRAP_LO  = 1;
   localparam int DEV_RW_BIT    = 0;
   localparam int ADDR_HI_W     = ADDR_W - BYTE_W;
   // Bit counter marks within one nine-clock word
   localparam logic [3:0] BIT_LAST = 4'h8;
   localparam logic [3:0] BIT_ACK  = 4'h9;
   // Programming time and clock
   localparam int PROG_TIME_MS  = 5;
   localparam int CLK_PERIOD_NS = 5;
   localparam int NS_PER_MS     = 1000000;
   localparam int PROG_CYCLES_DFLT = (PROG_TIME_MS * NS_PER_MS) / CLK_PERIOD_NS;
   // Pin synchroniser lane positions
   localparam int PIN_SCL   = 0;
   localparam int PIN_SDA   = 1;
   localparam int PIN_WP    = 2;
   localparam int PIN_STRAP = 3;
   localparam int PIN_W     = 6;
   typedef enum logic [2:0] {
      st_idle,
      st_dev,
      st_addr_hi,
      st_addr_lo,
      st_wdata,
      st_rdata,
      st_wait
   } link_state_t;
endpackage

/* src/pin_sync.sv */
`timescale 1ns/10ps
// Two-stage synchroniser for pins that arrive with no relation to the clock
module pin_sync
#(
   parameter int WIDTH = 1
)
(
   input  wire logic             clk_in,
   input  wire logic             rst_in,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_r;

   // Only the second stage is visible to the outside
   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         meta_r   <= '0;
         sync_out <= '0;
      end
      else
      begin
         meta_r   <= async_in;
         sync_out <= meta_r;
      end
   end
endmodule // pin_sync

/* src/serial_eeprom_two_wire_slave.sv */
`timescale 1ns/10ps
// How it works
// [R01] SDA fall with SCL high starts
// [R02] SDA rise with SCL high stops transfer
// [R03] Drive SDA only while SCL is low; the target holds its drive through SCL high
// [R04] Eight-bit words, acknowledge low on ninth clock
// [R05] Address bits three to one match straps
// [R06] Address word LSB: one reads, zero writes
// [R07] Match acknowledges; mismatch idles until start
// [R08] Write-protect high blocks every array write
// [R09] Two address bytes then data, all acknowledged
// [R10] Stop launches timed program; no acknowledge meanwhile
// [R11] Page write accepts up to 64 bytes
// [R12] Page write increments low six bits only
// [R13] Polling acknowledged only after program completes
// [R14] Counter holds last address plus one
// [R15] Read counter wraps last to first byte
// [R16] Current read sends byte at counter
// [R17] Random read uses dummy write first
// [R18] Controller acknowledge continues sequential read
// [R19] Standby at power-up and idle stop
// [R20] Controller recovers bus with start, nine clocks
// [R21] Word address is fifteen bits
// [R22] Array is 512 pages of 64 bytes
// [R23] Write-protect low permits normal access
// [R24] Upper nibble 1010; first address MSB ignored
// [R25] After read nack wait for start/stop
module serial_eeprom_two_wire_slave
   import eeprom_pkg::*;
#(
   parameter int PROG_CYCLES = PROG_CYCLES_DFLT
)
(
   input  wire logic ref_clk_in,
   input  wire logic rst_in,
   input  wire logic scl_in,
   input  wire logic sda_in,
   output logic      sda_out,
   output logic      sda_oe_out,
   input  wire logic strap_bit_zero_in,
   input  wire logic strap_bit_one_in,
   input  wire logic strap_bit_two_in,
   input  wire logic write_protect_in,
   output logic      standby_out,
   output logic      write_busy_out
);
   logic [PIN_W-1:0]      pins_raw;
   logic [PIN_W-1:0]      pins_s;
   logic                  scl_s;
   logic                  sda_s;
   logic                  wp_s;
   logic [2:0]            strap_s;
   logic                  scl_q_r;
   logic                  sda_q_r;
   logic                  scl_rise;
   logic                  scl_fall;
   logic                  start_det;
   logic                  stop_det;
   link_state_t           state_r;
   logic [3:0]            bit_cnt_r;
   logic [BYTE_W-1:0]     rx_sh_r;
   logic [BYTE_W-1:0]     tx_sh_r;
   logic [ADDR_HI_W-1:0]  addr_hi_r;
   logic [ADDR_W-1:0]     addr_cnt_r;
   logic [BYTE_W-1:0]     page_buf [PAGE_BYTES];
   logic [PAGE_BYTES-1:0] page_mask_r;
   logic [ROW_W-1:0]      page_row_r;
   logic                  wr_pend_r;
   logic                  prog_go;
   logic                  busy_r;
   logic [PAGE_OFS_W:0]   commit_idx_r;
   logic [31:0]           prog_timer_r;
   logic [BYTE_W-1:0]     mem [MEM_BYTES];
   logic                  dev_match;
   logic [BYTE_W-1:0]     rd_byte;

   // Every pin passes two flops before any logic sees it
   assign pins_raw = {strap_bit_two_in, strap_bit_one_in, strap_bit_zero_in,
                      write_protect_in, sda_in, scl_in};

   pin_sync #(
      .WIDTH (PIN_W)
   ) u_pin_sync (
      .clk_in   (ref_clk_in),
      .rst_in   (rst_in),
      .async_in (pins_raw),
      .sync_out (pins_s)
   );

   assign scl_s   = pins_s[PIN_SCL];
   assign sda_s   = pins_s[PIN_SDA];
   assign wp_s    = pins_s[PIN_WP];
   assign strap_s = pins_s[PIN_STRAP +: 3];

   // Delayed copies for edge and condition detection
   always_ff @(posedge ref_clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         scl_q_r <= 1'b1;
         sda_q_r <= 1'b1;
      end
      else
      begin
         scl_q_r <= scl_s;
         sda_q_r <= sda_s;
      end
   end

   // SDA moving while SCL stays high is a bus condition, never data
   assign scl_rise  = scl_s & ~scl_q_r;
   assign scl_fall  = ~scl_s & scl_q_r;
   assign start_det = scl_s & scl_q_r & sda_q_r & ~sda_s;    // see [R01] see [R03]
   assign stop_det  = scl_s & scl_q_r & ~sda_q_r & sda_s;    // see [R02] see [R03]

   // Type code, straps, and refusal while programming runs
   assign dev_match = (rx_sh_r[DEV_TYPE_HI:DEV_TYPE_LO] == DEV_TYPE_CODE)   // see [R24]
                    & (rx_sh_r[DEV_STRAP_HI:DEV_STRAP_LO] == strap_s)       // see [R05]
                    & ~busy_r;                                              // see [R13]

   // Asynchronous array read; the counter value is stable well before use
   assign rd_byte = mem[addr_cnt_r];                                        // see [R16]

   // Stop after a completed write launches programming unless protected
   assign prog_go = stop_det & (state_r == st_wdata) & wr_pend_r & ~wp_s;   // see [R08]

   // Protocol sequencer: word framing, address phases and direction
   always_ff @(posedge ref_clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         state_r   <= st_idle;                                      // see [R19]
         bit_cnt_r <= '0;
         rx_sh_r   <= '0;
         addr_hi_r <= '0;
         wr_pend_r <= 1'b0;
      end
      else if (start_det)
      begin
         // Repeated start is legal anywhere, including after a read nack;
         // an unfinished write is abandoned so a later stop cannot launch it
         state_r   <= st_dev;                                       // see [R25]
         bit_cnt_r <= '0;
         wr_pend_r <= 1'b0;
      end
      else if (stop_det)
      begin
         state_r   <= st_idle;                                      // see [R19]
         bit_cnt_r <= '0;
         wr_pend_r <= 1'b0;
      end
      else if (state_r == st_rdata)
      begin
         if (scl_rise && bit_cnt_r < BIT_LAST)
         begin
            bit_cnt_r <= bit_cnt_r + 4'h1;
         end
         else if (scl_rise && bit_cnt_r == BIT_LAST)
         begin
            // Low on the ninth clock asks for another byte
            if (!sda_s)
            begin
               bit_cnt_r <= BIT_ACK;                                // see [R18]
            end
            else
            begin
               state_r <= st_wait;                                  // see [R25]
            end
         end
         else if (scl_fall && bit_cnt_r == BIT_ACK)
         begin
            bit_cnt_r <= '0;
         end
      end
      else if (state_r != st_idle && state_r != st_wait)
      begin
         if (scl_rise && bit_cnt_r < BIT_LAST)
         begin
            rx_sh_r   <= {rx_sh_r[BYTE_W-2:0], sda_s};              // see [R04]
            bit_cnt_r <= bit_cnt_r + 4'h1;
         end
         else if (scl_fall && bit_cnt_r == BIT_LAST)
         begin
            bit_cnt_r <= BIT_ACK;
            case (state_r)
               st_dev:
               begin
                  if (!dev_match)
                  begin
                     state_r <= st_wait;                            // see [R07]
                  end
                  else if (rx_sh_r[DEV_RW_BIT])
                  begin
                     state_r <= st_rdata;                           // see [R06]
                  end
                  else
                  begin
                     state_r <= st_addr_hi;                         // see [R06]
                  end
               end
               st_addr_hi:
               begin
                  addr_hi_r <= rx_sh_r[ADDR_HI_W-1:0];              // see [R24]
                  state_r   <= st_addr_lo;                          // see [R09]
               end
               st_addr_lo:
               begin
                  state_r <= st_wdata;                              // see [R09]
               end
               st_wdata:
               begin
                  wr_pend_r <= 1'b1;                                // see [R11]
               end
               default:
               begin
                  state_r <= st_wait;
               end
            endcase
         end
         else if (scl_fall && bit_cnt_r == BIT_ACK)
         begin
            bit_cnt_r <= '0;
         end
      end
   end

   // Address counter: in-page wrap on writes, full wrap on reads
   always_ff @(posedge ref_clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         addr_cnt_r <= '0;
      end
      else if (!start_det && !stop_det && scl_fall)
      begin
         if (state_r == st_addr_lo && bit_cnt_r == BIT_LAST)
         begin
            addr_cnt_r <= {addr_hi_r, rx_sh_r};                     // see [R21]
         end
         else if (state_r == st_wdata && bit_cnt_r == BIT_LAST)
         begin
            // Row bits hold so a long page write overwrites its own page
            addr_cnt_r[PAGE_OFS_W-1:0] <= addr_cnt_r[PAGE_OFS_W-1:0] + 1'b1;  // see [R12]
         end
         else if (state_r == st_rdata && bit_cnt_r == BIT_ACK)
         begin
            addr_cnt_r <= addr_cnt_r + 1'b1;                        // see [R14] see [R15]
         end
      end
   end

   // Transmit shifter, loaded as the ack clock ends
   always_ff @(posedge ref_clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         tx_sh_r <= '0;
      end
      else if (state_r == st_rdata && scl_fall && !start_det && !stop_det)
      begin
         if (bit_cnt_r == BIT_ACK)
         begin
            tx_sh_r <= rd_byte;                                     // see [R16]
         end
         else if (bit_cnt_r != '0 && bit_cnt_r < BIT_LAST)
         begin
            tx_sh_r <= {tx_sh_r[BYTE_W-2:0], 1'b0};
         end
      end
   end

   // Page buffer collects bytes; programming copies it at the stop
   always_ff @(posedge ref_clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         page_mask_r <= '0;
         page_row_r  <= '0;
      end
      else if (scl_fall && bit_cnt_r == BIT_LAST && !start_det && !stop_det)
      begin
         if (state_r == st_addr_lo)
         begin
            page_mask_r <= '0;
            // Row is the word address above the six in-page bits
            page_row_r  <= {addr_hi_r, rx_sh_r[BYTE_W-1:PAGE_OFS_W]};  // see [R22]
         end
         else if (state_r == st_wdata)
         begin
            page_mask_r[addr_cnt_r[PAGE_OFS_W-1:0]] <= 1'b1;
         end
      end
   end

   always_ff @(posedge ref_clk_in)
   begin
      if (scl_fall && bit_cnt_r == BIT_LAST && state_r == st_wdata)
      begin
         page_buf[addr_cnt_r[PAGE_OFS_W-1:0]] <= rx_sh_r;           // see [R11]
      end
   end

   // Programming engine: copy marked bytes while the timer runs; busy holds for the full time from launch
   always_ff @(posedge ref_clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         busy_r       <= 1'b0;
         commit_idx_r <= '0;
         prog_timer_r <= '0;
      end
      else if (!busy_r)
      begin
         if (prog_go)
         begin
            busy_r       <= 1'b1;                                   // see [R10]
            commit_idx_r <= '0;
            prog_timer_r <= '0;
         end
      end
      else
      begin
         if (!commit_idx_r[PAGE_OFS_W])
         begin
            commit_idx_r <= commit_idx_r + 1'b1;
         end
         if (prog_timer_r >= 32'(PROG_CYCLES - 1) && commit_idx_r[PAGE_OFS_W])
         begin
            busy_r <= 1'b0;                                         // see [R13]
         end
         else
         begin
            prog_timer_r <= prog_timer_r + 32'h1;
         end
      end
   end

   // Array writes happen only inside a launched, unprotected program cycle
   always_ff @(posedge ref_clk_in)
   begin
      if (busy_r && !commit_idx_r[PAGE_OFS_W]
          && page_mask_r[commit_idx_r[PAGE_OFS_W-1:0]])
      begin
         mem[{page_row_r, commit_idx_r[PAGE_OFS_W-1:0]}] <=
            page_buf[commit_idx_r[PAGE_OFS_W-1:0]];                 // see [R08] see [R23]
      end
   end

   // SDA driver: changes only right after SCL falls
   always_ff @(posedge ref_clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         sda_oe_out <= 1'b0;
         sda_out    <= 1'b0;
      end
      else if (start_det || stop_det || state_r == st_idle || state_r == st_wait)
      begin
         sda_oe_out <= 1'b0;
      end
      else if (scl_fall)                                            // see [R03]
      begin
         if (bit_cnt_r == BIT_LAST && state_r != st_rdata)
         begin
            // Acknowledge every received word; a mismatch stays silent
            sda_oe_out <= (state_r != st_dev) | dev_match;          // see [R04] see [R07]
         end
         else if (state_r == st_rdata && bit_cnt_r == BIT_ACK)
         begin
            sda_oe_out <= ~rd_byte[BYTE_W-1];                       // see [R16]
         end
         else if (state_r == st_rdata && bit_cnt_r != '0 && bit_cnt_r < BIT_LAST)
         begin
            sda_oe_out <= ~tx_sh_r[BYTE_W-2];                       // see [R18]
         end
         else
         begin
            sda_oe_out <= 1'b0;
         end
      end
   end

   // Status pins
   always_ff @(posedge ref_clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         standby_out    <= 1'b1;
         write_busy_out <= 1'b0;
      end
      else
      begin
         standby_out    <= (state_r == st_idle || state_r == st_wait) & ~busy_r;  // see [R19]
         write_busy_out <= busy_r;                                  // see [R10]
      end
   end
endmodule // serial_eeprom_two_wire_slave

/* test/bus_ctl_model.sv */
`timescale 1ns/10ps
// Bus controller model; SCL runs only inside frames, idles high
module bus_ctl_model
#(
   parameter int Q = 64
)
(
   input  wire logic sda_in,
   output logic      scl_out,
   output logic      sda_pull_out
);
   initial
   begin
      scl_out = 1'b1;
      sda_pull_out = 1'b0;
   end
   // Non-blocking updates keep a change that lands on a clock edge out of its sample
   // Start or repeated start: SDA falls with SCL high
   task automatic start();
      sda_pull_out <= 1'b0;
      #Q scl_out <= 1'b1;
      #Q sda_pull_out <= 1'b1;
      #Q scl_out <= 1'b0;
      #Q;
   endtask
   // Stop: SDA rises with SCL high, then SCL stands still
   task automatic stop();
      sda_pull_out <= 1'b1;
      #Q scl_out <= 1'b1;
      #Q sda_pull_out <= 1'b0;
      #Q;
   endtask
   // One clock; data moves only while SCL is low
   task automatic bit_io(input logic b, output logic s);
      sda_pull_out <= ~b;
      #Q scl_out <= 1'b1;
      #Q s = sda_in;
      #Q scl_out <= 1'b0;
      #Q;
   endtask
   task automatic wbyte(input logic [7:0] v, output logic [7:0] ack);
      logic s;
      for (int k = 7; k >= 0; k--)
         bit_io(v[k], s);
      bit_io(1'b1, s);
      ack = {7'h00, s};
   endtask
   // Low on the ninth clock asks for more; high ends the read
   task automatic rbyte(input logic last, output logic [7:0] v);
      logic s;
      for (int k = 7; k >= 0; k--)
         bit_io(1'b1, v[k]);
      bit_io(last, s);
   endtask
endmodule // bus_ctl_model

/* test/eeprom_asserts.sv */
`timescale 1ns/10ps
// Port-level checks of the bus target
module eeprom_asserts
#(
   parameter int PROG_CYCLES = 1000
)
(
   input wire logic ref_clk_in,
   input wire logic rst_in,
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic sda_out,
   input wire logic sda_oe_out,
   input wire logic strap_bit_zero_in,
   input wire logic strap_bit_one_in,
   input wire logic strap_bit_two_in,
   input wire logic write_protect_in,
   input wire logic standby_out,
   input wire logic write_busy_out
);
   logic [31:0] busy_len_r;
   default clocking @(posedge ref_clk_in);
   endclocking
   default disable iff (rst_in);
   // Length of the running program cycle
   always_ff @(posedge ref_clk_in or posedge rst_in)
   begin
      if (rst_in)
         busy_len_r <= 32'h0;
      else if (write_busy_out)
         busy_len_r <= busy_len_r + 32'h1;
      else
         busy_len_r <= 32'h0;
   end
   open_drain_a: assert property (sda_out == 1'b0)
      else $error("sda_out not low");
   busy_not_idle_a: assert property (write_busy_out |-> !standby_out)
      else $error("standby during program");
   busy_silent_a: assert property (write_busy_out |-> !sda_oe_out)
      else $error("drive during program");
   // Sync delay means a change must land well inside the low phase
   drive_scl_low_a: assert property ($changed(sda_oe_out) |-> !scl_in && !$past(scl_in))
      else $error("sda changed while scl high");
   drive_awake_a: assert property (sda_oe_out |-> !standby_out)
      else $error("drive while in standby");
   // Pin level four edges back is the one the launch decision used
   wp_block_a: assert property ($rose(write_busy_out) |-> !$past(write_protect_in, 4))
      else $error("program started while protected");
   prog_len_a: assert property ($fell(write_busy_out) |->
      busy_len_r >= PROG_CYCLES && busy_len_r <= PROG_CYCLES + 64)
      else $error("program cycle length off");
   stop_idle_a: assert property (scl_in && $rose(sda_in) |->
      ##[1:8] (standby_out || write_busy_out))
      else $error("no standby after stop");
endmodule // eeprom_asserts

bind serial_eeprom_two_wire_slave eeprom_asserts #(.PROG_CYCLES(PROG_CYCLES)) chk (
   .ref_clk_in(ref_clk_in), .rst_in(rst_in), .scl_in(scl_in), .sda_in(sda_in),
   .sda_out(sda_out), .sda_oe_out(sda_oe_out), .strap_bit_zero_in(strap_bit_zero_in),
   .strap_bit_one_in(strap_bit_one_in), .strap_bit_two_in(strap_bit_two_in),
   .write_protect_in(write_protect_in), .standby_out(standby_out),
   .write_busy_out(write_busy_out));

/* test/serial_eeprom_two_wire_slave_tb.sv */
`timescale 1ns/10ps
module serial_eeprom_two_wire_slave_tb;
   localparam int         PROG = 1000;
   localparam logic [7:0] DEV  = 8'haa; // Straps 3'b101 sit in bits three to one
   typedef struct {logic [14:0] a; logic [7:0] v; logic p; logic [7:0] e;} row_t;
   row_t       rows [3];
   logic       ref_clk_in, rst_in, wp, scl, pull, oe, busy, sby;
   logic [2:0] strap;
   logic [7:0] ack, d;
   int         error_cnt, check_count, cyc;
   wire        sda_w = ~(oe | pull); // Pulled up; either side may hold it low

   serial_eeprom_two_wire_slave #(.PROG_CYCLES(PROG)) dut (.ref_clk_in(ref_clk_in),
      .rst_in(rst_in), .scl_in(scl), .sda_in(sda_w), .sda_out(), .sda_oe_out(oe),
      .strap_bit_zero_in(strap[0]), .strap_bit_one_in(strap[1]),
      .strap_bit_two_in(strap[2]), .write_protect_in(wp), .standby_out(sby),
      .write_busy_out(busy));
   bus_ctl_model ctl (.sda_in(sda_w), .scl_out(scl), .sda_pull_out(pull));

   task automatic check(input string nm, input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // Device word and both word-address bytes; top address bit is junk
   task automatic addr_ph(input logic [14:0] a);
      ctl.start();
      ctl.wbyte(DEV, ack);
      check("dev ack", ack, 8'h00);
      ctl.wbyte({1'b1, a[14:8]}, ack);
      check("hi ack", ack, 8'h00);
      ctl.wbyte(a[7:0], ack);
      check("lo ack", ack, 8'h00);
   endtask
   task automatic rd_start();
      ctl.start();
      ctl.wbyte(DEV | 8'h01, ack);
      check("rd ack", ack, 8'h00);
   endtask
   task automatic rd_chk(input logic [7:0] e, input logic last);
      ctl.rbyte(last, d);
      check("rd data", d, e);
   endtask
   // Poll until answered; a real program cycle needs more than one try
   task automatic poll(input logic [7:0] slow);
      int n;
      n = 0;
      ack = 8'h01;
      while (ack !== 8'h00 && n < 30)
      begin
         ctl.start();
         ctl.wbyte(DEV, ack);
         n++;
      end
      ctl.stop();
      check("poll ack", ack, 8'h00);
      check("poll", {7'h00, (n > 1)}, slow);
   endtask

   initial
   begin
      ref_clk_in = 1'b0;
      forever #2.5 ref_clk_in = ~ref_clk_in;
   end
   // Hang guard
   always @(posedge ref_clk_in)
   begin
      cyc++;
      if (cyc == 90000)
      begin
         error_cnt++;
         conclude();
      end
   end

   initial
   begin
      rst_in = 1'b1;
      wp = 1'b0;
      strap = 3'b101;
      rows = '{'{15'h0000, 8'h5a, 1'b0, 8'h5a}, '{15'h7fff, 8'ha5, 1'b0, 8'ha5},
               '{15'h0000, 8'h33, 1'b1, 8'h5a}};
      repeat (12) @(posedge ref_clk_in);
      check("rst drive", {7'h00, oe}, 8'h00);
      check("rst standby", {7'h00, sby}, 8'h01);
      $display("reset done");
      rst_in <= 1'b0;
      repeat (4) @(posedge ref_clk_in);
      // Write one byte, wait out programming, read it back at random
      foreach (rows[k])
      begin
         wp <= rows[k].p;
         repeat (10) @(posedge ref_clk_in);
         addr_ph(rows[k].a);
         ctl.wbyte(rows[k].v, ack);
         check("data ack", ack, 8'h00);
         ctl.stop();
         repeat (20) @(posedge ref_clk_in);
         check("busy", {7'h00, busy}, {7'h00, ~rows[k].p});
         poll({7'h00, ~rows[k].p});
         addr_ph(rows[k].a);
         rd_start();
         rd_chk(rows[k].e, 1'b1);
         ctl.stop();
         $display("row %0d done", k);
      end
      wp <= 1'b0;
      // Page write across the page end folds back to the page start
      addr_ph(15'h003e);
      for (int j = 0; j < 4; j++)
      begin
         ctl.wbyte(8'hc0 + 8'(j), ack);
         check("page ack", ack, 8'h00);
      end
      ctl.stop();
      poll(8'h01);
      addr_ph(15'h003e);
      rd_start();
      rd_chk(8'hc0, 1'b0);
      rd_chk(8'hc1, 1'b1);
      ctl.stop();
      $display("page wrap done");
      // Read off the array end, then a bare current-address read
      addr_ph(15'h7fff);
      rd_start();
      rd_chk(8'ha5, 1'b0);
      rd_chk(8'hc2, 1'b1);
      ctl.stop();
      rd_start();
      rd_chk(8'hc3, 1'b1);
      ctl.stop();
      $display("read wrap done");
      // Foreign straps and foreign type code are ignored
      ctl.start();
      ctl.wbyte(8'ha2, ack);
      check("strap nack", ack, 8'h01);
      ctl.start();
      ctl.wbyte(8'hba, ack);
      check("type nack", ack, 8'h01);
      ctl.stop();
      repeat (10) @(posedge ref_clk_in);
      check("standby", {7'h00, sby}, 8'h01);
      $display("mismatch done");
      // Cut a read while the target holds SDA low on a zero bit, then recover
      addr_ph(15'h003e);
      rd_start();
      repeat (2) ctl.bit_io(1'b1, d[0]);
      check("held low", {7'h00, sda_w}, 8'h00);
      ctl.start();
      repeat (9) ctl.bit_io(1'b1, d[0]);
      ctl.start();
      ctl.stop();
      repeat (10) @(posedge ref_clk_in);
      check("recover standby", {7'h00, sby}, 8'h01);
      // The cut byte was accessed, so the counter stands one past it
      rd_start();
      rd_chk(8'hc1, 1'b1);
      ctl.stop();
      $display("recovery done");
      conclude();
   end
endmodule // serial_eeprom_two_wire_slave_tb
